// File: src/pin_change_detect.sv
// top: pin change detector for three eight-pin ports with register port and interrupt
`timescale 1ns/10ps
module pin_change_detect (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_c_pins,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic change_irq,
  output logic event_irq,
  output logic wake
);
  localparam int NP = pin_change_pkg::NUM_PORTS;

  pin_change_pkg::reg_req_type req;
  logic [7:0] pins [NP];
  logic [7:0] rise_enable_reg [NP];
  logic [7:0] fall_enable_reg [NP];
  logic [7:0] pin_change_flag_reg [NP];
  logic [NP-1:0] flag_write;
  logic [NP-1:0] port_event;
  logic [7:0] interrupt_control_reg;
  logic change_irq_master_enable;
  logic change_summary_flag;
  logic any_event;
  logic [3:0] irq_status_r;
  logic [3:0] irq_status_nxt;
  logic [3:0] irq_mask_r;
  logic [3:0] ev_set;
  pin_change_pkg::power_state_type power_r;
  logic change_irq_r;
  logic event_irq_r;
  logic wake_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [NP-1:0] summary_parts;

  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_write;
  assign req.rd = reg_read;

  assign pins[0] = port_a_pins;
  assign pins[1] = port_b_pins;
  assign pins[2] = port_c_pins;

  // per-port register index: base offsets step by three
  function automatic logic [3:0] port_ofs(input int p, input logic [3:0] base);
    logic [3:0] step;
    step = 4'(p) * pin_change_pkg::PORTS_PER_GROUP;
    return base + step;
  endfunction : port_ofs

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_port
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          rise_enable_reg[gi] <= pin_change_pkg::ENABLE_RESET;
          fall_enable_reg[gi] <= pin_change_pkg::ENABLE_RESET;
        end else if (req.wr) begin
          if (req.addr == port_ofs(gi, pin_change_pkg::RISE_EN_A_OFS)) begin
            rise_enable_reg[gi] <= req.wdata;
          end
          if (req.addr == port_ofs(gi, pin_change_pkg::FALL_EN_A_OFS)) begin
            fall_enable_reg[gi] <= req.wdata;
          end
        end
      end

      assign flag_write[gi] = req.wr && (req.addr == port_ofs(gi, pin_change_pkg::FLAG_A_OFS));

      pin_edge_port u_port (
        .sys_clk(sys_clk),
        .reset(reset),
        .pins(pins[gi]),
        .rise_enable(rise_enable_reg[gi]),
        .fall_enable(fall_enable_reg[gi]),
        .flag_write(flag_write[gi]),
        .flag_wdata(req.wdata),
        .flags(pin_change_flag_reg[gi]),
        .edge_event(port_event[gi])
      );

      assign summary_parts[gi] = |pin_change_flag_reg[gi];
    end
  endgenerate

  // summary is read-only and live; a write to its bit is ignored
  assign change_summary_flag = |summary_parts;
  assign any_event = |port_event;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      change_irq_master_enable <= 1'b0;
    end else if (req.wr && req.addr == pin_change_pkg::INT_CTRL_OFS) begin
      change_irq_master_enable <= req.wdata[pin_change_pkg::MASTER_EN_BIT];
    end
  end

  always_comb begin
    interrupt_control_reg = pin_change_pkg::CTRL_RESET;
    interrupt_control_reg[pin_change_pkg::MASTER_EN_BIT] = change_irq_master_enable;
    interrupt_control_reg[pin_change_pkg::SUMMARY_BIT] = change_summary_flag;
  end

  // request follows the flags; master off leaves flags working but silent
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      change_irq_r <= 1'b0;
    end else begin
      change_irq_r <= change_summary_flag && change_irq_master_enable;
    end
  end

  // sleep state: software enters it, an enabled change with master on leaves it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_r <= pin_change_pkg::awake_st;
    end else begin
      unique case (power_r)
        pin_change_pkg::awake_st: begin
          if (req.wr && req.addr == pin_change_pkg::SLEEP_CTRL_OFS
              && req.wdata[pin_change_pkg::SLEEP_BIT]) begin
            power_r <= pin_change_pkg::sleep_st;
          end
        end
        pin_change_pkg::sleep_st: begin
          // flags are set in this same edge, which is also the edge on which wake rises
          if (any_event && change_irq_master_enable) begin
            power_r <= pin_change_pkg::awake_st;
          end
        end
      endcase
    end
  end

  // wake pulses one cycle, rising on the same edge that sets the flag
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= (power_r == pin_change_pkg::sleep_st) && any_event && change_irq_master_enable;
    end
  end

  // event status: sticky, write one to clear, set wins over clear
  always_comb begin
    ev_set = 4'h0;
    ev_set[pin_change_pkg::EV_PORT_A_BIT] = port_event[0];
    ev_set[pin_change_pkg::EV_PORT_B_BIT] = port_event[1];
    ev_set[pin_change_pkg::EV_PORT_C_BIT] = port_event[2];
    ev_set[pin_change_pkg::EV_WAKE_BIT] = (power_r == pin_change_pkg::sleep_st) && any_event
                                          && change_irq_master_enable;
    irq_status_nxt = irq_status_r;
    if (req.wr && req.addr == pin_change_pkg::IRQ_STATUS_OFS) begin
      irq_status_nxt = irq_status_nxt & ~req.wdata[3:0];
    end
    irq_status_nxt = irq_status_nxt | ev_set;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_status_r <= 4'h0;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_mask_r <= 4'h0;
    end else if (req.wr && req.addr == pin_change_pkg::IRQ_MASK_OFS) begin
      irq_mask_r <= req.wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      event_irq_r <= 1'b0;
    end else begin
      event_irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = pin_change_pkg::READ_IDLE;
    if (req.rd) begin
      unique case (req.addr)
        pin_change_pkg::RISE_EN_A_OFS: rdata_nxt = rise_enable_reg[0];
        pin_change_pkg::FALL_EN_A_OFS: rdata_nxt = fall_enable_reg[0];
        pin_change_pkg::FLAG_A_OFS: rdata_nxt = pin_change_flag_reg[0];
        pin_change_pkg::RISE_EN_B_OFS: rdata_nxt = rise_enable_reg[1];
        pin_change_pkg::FALL_EN_B_OFS: rdata_nxt = fall_enable_reg[1];
        pin_change_pkg::FLAG_B_OFS: rdata_nxt = pin_change_flag_reg[1];
        pin_change_pkg::RISE_EN_C_OFS: rdata_nxt = rise_enable_reg[2];
        pin_change_pkg::FALL_EN_C_OFS: rdata_nxt = fall_enable_reg[2];
        pin_change_pkg::FLAG_C_OFS: rdata_nxt = pin_change_flag_reg[2];
        pin_change_pkg::INT_CTRL_OFS: rdata_nxt = interrupt_control_reg;
        pin_change_pkg::IRQ_STATUS_OFS: rdata_nxt = {4'h0, irq_status_r};
        pin_change_pkg::IRQ_MASK_OFS: rdata_nxt = {4'h0, irq_mask_r};
        pin_change_pkg::SLEEP_CTRL_OFS: rdata_nxt = {7'h00, power_r == pin_change_pkg::sleep_st};
        default: rdata_nxt = pin_change_pkg::READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= pin_change_pkg::READ_IDLE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign change_irq = change_irq_r;
  assign event_irq = event_irq_r;
  assign wake = wake_r;
endmodule : pin_change_detect

// File: src/pin_change_pkg.sv
// package: register map, field positions and carrier types for the pin change detector
package pin_change_pkg;
  localparam int NUM_PORTS = 3;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 4;
  localparam int DATA_WIDTH = 8;

  // register offsets
  localparam logic [3:0] RISE_EN_A_OFS = 4'h0;
  localparam logic [3:0] FALL_EN_A_OFS = 4'h1;
  localparam logic [3:0] FLAG_A_OFS = 4'h2;
  localparam logic [3:0] RISE_EN_B_OFS = 4'h3;
  localparam logic [3:0] FALL_EN_B_OFS = 4'h4;
  localparam logic [3:0] FLAG_B_OFS = 4'h5;
  localparam logic [3:0] RISE_EN_C_OFS = 4'h6;
  localparam logic [3:0] FALL_EN_C_OFS = 4'h7;
  localparam logic [3:0] FLAG_C_OFS = 4'h8;
  localparam logic [3:0] INT_CTRL_OFS = 4'h9;
  localparam logic [3:0] IRQ_STATUS_OFS = 4'hA;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hB;
  localparam logic [3:0] SLEEP_CTRL_OFS = 4'hC;
  localparam logic [3:0] PORTS_PER_GROUP = 4'h3;

  // interrupt control register fields
  localparam int MASTER_EN_BIT = 0;
  localparam int SUMMARY_BIT = 1;
  // event status/mask fields
  localparam int EV_PORT_A_BIT = 0;
  localparam int EV_PORT_B_BIT = 1;
  localparam int EV_PORT_C_BIT = 2;
  localparam int EV_WAKE_BIT = 3;
  localparam int EV_WIDTH = 4;
  // sleep control field
  localparam int SLEEP_BIT = 0;

  // reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef enum logic [0:0] {
    awake_st,
    sleep_st
  } power_state_type;
endpackage : pin_change_pkg

// File: src/pin_edge_port.sv
// one port of eight pins: synchroniser, edge detectors and flag register
`timescale 1ns/10ps
module pin_edge_port (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] pins,
  input wire logic [7:0] rise_enable,
  input wire logic [7:0] fall_enable,
  input wire logic flag_write,
  input wire logic [7:0] flag_wdata,
  output logic [7:0] flags,
  output logic edge_event
);
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] prev_r;
  logic [7:0] flag_r;
  logic [7:0] flag_nxt;
  logic [7:0] hit;
  logic [2:0] prime_r;

  // two-stage synchroniser; stage one feeds stage two only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      prev_r <= 8'h00;
      prime_r <= 3'h0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      prime_r <= {prime_r[1:0], 1'b1};
    end
  end

  // independent rise and fall detectors, each gated by its own enable bit
  // held off until prev_r holds a real sample: a pin idling high must not look like an edge after reset
  assign hit = {8{prime_r[2]}} & ((rise_enable & sync2_r & ~prev_r)
             | (fall_enable & ~sync2_r & prev_r));

  always_comb begin
    flag_nxt = flag_r;
    if (flag_write) begin
      flag_nxt = flag_wdata;
    end
    // a fresh edge wins over any write in the same cycle
    flag_nxt = flag_nxt | hit;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flag_r <= pin_change_pkg::FLAG_RESET;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flags = flag_r;
  assign edge_event = |hit;
endmodule : pin_edge_port

// File: testbench/pin_source.sv
// far side model: external pin levels of the three ports
`timescale 1ns/10ps
module pin_source (
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins,
  output logic [7:0] port_c_pins
);
  initial begin
    port_a_pins = 8'h00;
    port_b_pins = 8'h00;
    port_c_pins = 8'h00;
  end
  // clean steps only, so every change is exactly one edge per pin
  task automatic drive(input int p, input logic [7:0] v);
    case (p)
      0: port_a_pins <= v;
      1: port_b_pins <= v;
      default: port_c_pins <= v;
    endcase
  endtask : drive
endmodule : pin_source

// File: testbench/pin_change_detect_monitor.sv
// checker: port timing relations of the pin change detector
`timescale 1ns/10ps
module pin_change_detect_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_c_pins,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic change_irq,
  input wire logic event_irq,
  input wire logic wake
);
  logic [23:0] pins_r;
  logic [7:0] act_r;
  logic [7:0] wr_r;
  wire logic [23:0] pins_now = {port_c_pins, port_b_pins, port_a_pins};
  // eight cycles of history covers the sync plus flag plus output latency
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pins_r <= 24'h000000;
      act_r <= 8'h00;
      wr_r <= 8'h00;
    end else begin
      pins_r <= pins_now;
      act_r <= {act_r[6:0], reg_write | (pins_now != pins_r)};
      wr_r <= {wr_r[6:0], reg_write};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_unmapped_read;
    reg_read && reg_addr > 4'hC;
  endsequence
  property p_irq_rise; $rose(change_irq) |-> |act_r; endproperty
  property p_irq_fall; $fell(change_irq) |-> |wr_r; endproperty
  property p_ev_rise; $rose(event_irq) |-> |act_r; endproperty
  property p_ev_fall; $fell(event_irq) |-> |wr_r; endproperty
  property p_wake_pulse; wake |=> !wake; endproperty
  property p_wake_cause; wake |-> |act_r; endproperty
  property p_rd_slot; reg_rdata != 8'h00 |-> $past(reg_read); endproperty
  property p_rd_unmapped; s_unmapped_read |=> reg_rdata == 8'h00; endproperty
  property p_rst_quiet; $fell(reset) |-> !change_irq && !event_irq && !wake; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("change_irq rose without cause");
  a_irq_fall: assert property (p_irq_fall) else $error("change_irq fell without write");
  a_ev_rise: assert property (p_ev_rise) else $error("event_irq rose without cause");
  a_ev_fall: assert property (p_ev_fall) else $error("event_irq fell without write");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
  a_wake_cause: assert property (p_wake_cause) else $error("wake without pin change");
  a_rd_slot: assert property (p_rd_slot) else $error("read data outside its slot");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_rst_quiet: assert property (p_rst_quiet) else $error("output high after reset");
endmodule : pin_change_detect_monitor
bind pin_change_detect pin_change_detect_monitor u_pin_change_detect_monitor (.sys_clk(sys_clk), .reset(reset),
  .port_a_pins(port_a_pins), .port_b_pins(port_b_pins), .port_c_pins(port_c_pins), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .change_irq(change_irq), .event_irq(event_irq), .wake(wake));

// File: testbench/testbench.sv
// testbench: register level tests of the pin change detector
`timescale 1ns/10ps
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata, pa, pb, pc;
  logic change_irq, event_irq, wake, w;
  int mismatches = 0;
  int checks_done = 0;
  always #50 sys_clk = ~sys_clk;
  pin_source u_pin_source (.port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc));
  pin_change_detect u_pin_change_detect (.sys_clk(sys_clk), .reset(reset), .port_a_pins(pa), .port_b_pins(pb),
    .port_c_pins(pc), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .change_irq(change_irq), .event_irq(event_irq), .wake(wake));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  // data stands one cycle only, so it is taken just after the answering edge
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    wr(4'hE, 8'hFF);
    for (int i = 0; i < 15; i++) rd(4'(i), 8'h00);
    $display("test reset done");
    wr(pin_change_pkg::RISE_EN_A_OFS, 8'h0F);
    wr(pin_change_pkg::FALL_EN_A_OFS, 8'hF0);
    rd(pin_change_pkg::FALL_EN_A_OFS, 8'hF0);
    @(posedge sys_clk);
    u_pin_source.drive(0, 8'hFF);
    tick(4);
    rd(pin_change_pkg::FLAG_A_OFS, 8'h0F);
    @(posedge sys_clk);
    u_pin_source.drive(0, 8'h00);
    tick(4);
    rd(pin_change_pkg::FLAG_A_OFS, 8'hFF);
    rd(pin_change_pkg::INT_CTRL_OFS, 8'h02);
    chk({7'h00, change_irq}, 8'h00);
    rd(pin_change_pkg::IRQ_STATUS_OFS, 8'h01);
    wr(pin_change_pkg::IRQ_MASK_OFS, 8'h01);
    tick(2);
    chk({7'h00, event_irq}, 8'h01);
    wr(pin_change_pkg::INT_CTRL_OFS, 8'h03);
    tick(2);
    chk({7'h00, change_irq}, 8'h01);
    wr(pin_change_pkg::FLAG_A_OFS, 8'hFF & ~8'h0F);
    rd(pin_change_pkg::FLAG_A_OFS, 8'hF0);
    wr(pin_change_pkg::FLAG_A_OFS, 8'h00);
    wr(pin_change_pkg::IRQ_STATUS_OFS, 8'h01);
    tick(2);
    chk({6'h00, event_irq, change_irq}, 8'h00);
    rd(pin_change_pkg::INT_CTRL_OFS, 8'h01);
    $display("test flags done");
    wr(pin_change_pkg::RISE_EN_B_OFS, 8'h01);
    wr(pin_change_pkg::FALL_EN_B_OFS, 8'h01);
    wr(pin_change_pkg::SLEEP_CTRL_OFS, 8'h01);
    rd(pin_change_pkg::SLEEP_CTRL_OFS, 8'h01);
    @(posedge sys_clk);
    u_pin_source.drive(1, 8'h01);
    w = 1'b0;
    for (int k = 0; k < 10 && w !== 1'b1; k++) begin
      tick(1);
      w = wake;
    end
    chk({7'h00, w}, 8'h01);
    rd(pin_change_pkg::FLAG_B_OFS, 8'h01);
    rd(pin_change_pkg::SLEEP_CTRL_OFS, 8'h00);
    rd(pin_change_pkg::IRQ_STATUS_OFS, 8'h0A);
    wr(pin_change_pkg::FLAG_B_OFS, 8'h00);
    @(posedge sys_clk);
    u_pin_source.drive(1, 8'h00);
    tick(4);
    rd(pin_change_pkg::FLAG_B_OFS, 8'h01);
    $display("test wake done");
    wr(pin_change_pkg::RISE_EN_C_OFS, 8'h80);
    @(posedge sys_clk);
    u_pin_source.drive(2, 8'h80);
    @(posedge sys_clk);
    wr(pin_change_pkg::FLAG_C_OFS, 8'h00);
    rd(pin_change_pkg::FLAG_C_OFS, 8'h80);
    @(posedge sys_clk);
    reset <= 1'b1;
    tick(2);
    @(posedge sys_clk);
    reset <= 1'b0;
    // port c pin 7 stays high across reset: an early rise enable must not flag it
    wr(pin_change_pkg::RISE_EN_C_OFS, 8'h80);
    rd(pin_change_pkg::RISE_EN_A_OFS, 8'h00);
    rd(pin_change_pkg::FLAG_C_OFS, 8'h00);
    $display("test set_wins done");
    final_report();
  end
endmodule : testbench
